//--- inc/spi_crc_cfg.svh
// Purpose: Offsets, bit positions, reset values of the SPI data/CRC block
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, one register per word
// Notes:   Definitions only
`ifndef SPI_CRC_CFG_SVH
`define SPI_CRC_CFG_SVH
`define OFS_CTRL    8'h00
`define OFS_STS     8'h08
`define OFS_DATA    8'h0C
`define OFS_POLY    8'h10
`define OFS_RX_CRC_VALUE    8'h14
`define OFS_TX_CRC_VALUE    8'h18
`define OFS_MODE    8'h1C
`define OFS_IMASK   8'h24
`define OFS_ISTAT   8'h28
`define BIT_ENABLE  6
`define BIT_WIDTH   11
`define BIT_CRCNEXT 12
`define BIT_CRCEN   13
`define BIT_AUDIO   11
`define BIT_BUSY    7
`define BIT_CRC_MISMATCH_FLAG    4
`define BIT_TE      1
`define BIT_RNE     0
`define POLY_RESET  16'h0007
`define CRC_RESET   16'h0000
`endif

//--- inc/spi_crc_pkg.sv
// Purpose: Types and CRC arithmetic shared by the SPI data/CRC block
// Assumes: Frames of 8 or 16 bits, MSB first
// Notes:   crcStep folds one whole frame into an accumulator
`default_nettype none
package spi_crc_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE  = 3'b100
  } link_state_t;

  // One frame into the CRC, bitwise; 8-bit mode keeps only the low byte
  function automatic word_t crcStep(word_t c, word_t d, word_t p, logic w);
    word_t  r;
    logic   fb;
    integer i;
    r = c;
    for (i = 15; i >= 0; i = i - 1) begin
      if (w || i < 8) begin
        fb = (w ? r[15] : r[7]) ^ d[i];
        r  = {r[14:0], 1'b0};
        if (fb) begin
          r = r ^ p;
        end
      end
    end
    if (!w) begin
      r[15:8] = 8'h00;
    end
    return r;
  endfunction
endpackage
`default_nettype wire

//--- inc/frame_link_if.sv
// Purpose: Frame hand-off between control, shift engine and CRC unit
// Assumes: All signals on mclk
// Notes:   takeTx and rxDone are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface frame_link_if;
  import spi_crc_pkg::*;
  word_t txWord;   // Word for the next frame
  logic  txValid;  // txWord holds unsent data
  logic  wide;     // 16-bit frames
  logic  run;      // Interface enabled
  logic  takeTx;   // Engine took txWord
  word_t rxWord;   // Last received frame
  logic  rxDone;   // Frame received
  logic  active;   // Frame in progress
  modport ctl (output txWord, txValid, wide, run, input takeTx, rxWord, rxDone, active);
  modport eng (input txWord, txValid, wide, run, output takeTx, rxWord, rxDone, active);
  modport mon (input txWord, txValid, wide, run, takeTx, rxWord, rxDone, active);
endinterface
`default_nettype wire

//--- logic/spi_shift_engine.sv
// Purpose: SPI slave shift engine, mode 0, MSB first
// Assumes: sck, selN, mosi are asynchronous pins sampled by mclk
// Notes:   Link clock must stay well below mclk/4
`timescale 1ns/1ps
`default_nettype none
module spi_shift_engine (
  input  wire logic   mclk,
  input  wire logic   reset_n,
  input  wire logic   ce,
  input  wire logic   sck,
  input  wire logic   selN,
  input  wire logic   mosi,
  output logic        miso,
  output logic        misoOe,
  frame_link_if.eng   link
);
  import spi_crc_pkg::*;

  logic [2:0]  syncA_reg, syncB_reg;  // Two-stage pin synchronisers
  logic        sckP_reg;              // Previous synced sck
  link_state_t state_reg, state_next;
  word_t       shOut_reg, shOut_next; // Outgoing shift
  word_t       shIn_reg, shIn_next;   // Incoming shift
  word_t       rxW_reg, rxW_next;     // Captured frame
  logic [3:0]  cnt_reg, cnt_next;     // Bits sampled
  logic        miso_reg, miso_next;
  logic        sckS, selOn, mosiS, sckRise, sckFall;
  logic [3:0]  lastIdx;

  // Top bit of a word for the current frame width
  function automatic logic topBit(word_t v, logic w);
    return w ? v[15] : v[7];
  endfunction

  assign sckS    = syncB_reg[0];
  assign selOn   = !syncB_reg[1] && link.run;
  assign mosiS   = syncB_reg[2];
  assign sckRise = sckS && !sckP_reg;
  assign sckFall = !sckS && sckP_reg;
  assign lastIdx = link.wide ? 4'hF : 4'h7;

  // ----------------------------------------
  // Frame sequencing
  // ----------------------------------------
  always_comb begin
    state_next  = state_reg;
    shOut_next  = shOut_reg;
    shIn_next   = shIn_reg;
    rxW_next    = rxW_reg;
    cnt_next    = cnt_reg;
    miso_next   = miso_reg;
    link.takeTx = 1'b0;
    link.rxDone = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (selOn) begin
          // Empty buffer sends zeros rather than stale data
          state_next  = ST_SHIFT;
          shOut_next  = link.txValid ? link.txWord : 16'h0000;
          miso_next   = link.txValid ? topBit(link.txWord, link.wide) : 1'b0;
          link.takeTx = link.txValid;
          cnt_next    = 4'h0;
        end
      end
      ST_SHIFT: begin
        if (!selOn) begin
          state_next = ST_IDLE; // Aborted frame is dropped
        end else begin
          if (sckRise) begin
            shIn_next = {shIn_reg[14:0], mosiS};
            cnt_next  = cnt_reg + 4'h1;
            if (cnt_reg == lastIdx) begin
              state_next = ST_DONE;
              rxW_next   = {shIn_reg[14:0], mosiS};
            end
          end
          // No shift before the first rise, so back-to-back frames keep MSB
          if (sckFall && cnt_reg != 4'h0) begin
            shOut_next = {shOut_reg[14:0], 1'b0};
            miso_next  = topBit({shOut_reg[14:0], 1'b0}, link.wide);
          end
        end
      end
      ST_DONE: begin
        link.rxDone = 1'b1;
        state_next  = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // Idle pin levels: select high, clock low, so no false edge or select
      syncA_reg <= 3'h2;
      syncB_reg <= 3'h2;
      sckP_reg  <= 1'b0;
      state_reg <= ST_IDLE;
      shOut_reg <= 16'h0000;
      shIn_reg  <= 16'h0000;
      rxW_reg   <= 16'h0000;
      cnt_reg   <= 4'h0;
      miso_reg  <= 1'b0;
    end else if (ce) begin
      syncA_reg <= {mosi, selN, sck};
      syncB_reg <= syncA_reg;
      sckP_reg  <= sckS;
      state_reg <= state_next;
      shOut_reg <= shOut_next;
      shIn_reg  <= shIn_next;
      rxW_reg   <= rxW_next;
      cnt_reg   <= cnt_next;
      miso_reg  <= miso_next;
    end
  end

  assign link.rxWord = rxW_reg;
  assign link.active = state_reg != ST_IDLE;
  assign miso        = miso_reg;
  assign misoOe      = !syncB_reg[1];

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence lastBit;
    ce && state_reg == ST_SHIFT && selOn && sckRise && cnt_reg == lastIdx;
  endsequence
  // The done state holds while ce is low, so rxDone shows on the next edge
  frame_end_a: assert property (lastBit |=> link.rxDone)
    else $error("frame end without rxDone");
  done_pulse_a: assert property (link.rxDone && ce |=> !link.rxDone)
    else $error("rxDone longer than one cycle");
endmodule // spi_shift_engine
`default_nettype wire

//--- logic/spi_crc_unit.sv
// Purpose: Running receive and transmit CRC accumulators
// Assumes: One takeTx / rxDone pulse per frame
// Notes:   Polynomial and width sampled at fold time
`timescale 1ns/1ps
`default_nettype none
`include "spi_crc_cfg.svh"
module spi_crc_unit (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  frame_link_if.mon         link,
  input  wire logic [15:0]  poly,
  input  wire logic         crcOn,
  input  wire logic         crcClear,
  input  wire logic         skipRx,
  output logic      [15:0]  rxCrc,
  output logic      [15:0]  txCrc
);
  import spi_crc_pkg::*;

  word_t rx_reg, rx_next; // Receive accumulator
  word_t tx_reg, tx_next; // Transmit accumulator

  // ----------------------------------------
  // Accumulate per frame
  // ----------------------------------------
  always_comb begin
    rx_next = rx_reg;
    tx_next = tx_reg;
    if (crcClear) begin
      rx_next = `CRC_RESET;
      tx_next = `CRC_RESET;
    end else if (crcOn) begin
      // Received CRC frame itself is compared, not folded
      if (link.rxDone && !skipRx) begin
        rx_next = crcStep(rx_reg, link.rxWord, poly, link.wide);
      end
      if (link.takeTx) begin
        tx_next = crcStep(tx_reg, link.txWord, poly, link.wide);
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_reg <= `CRC_RESET;
      tx_reg <= `CRC_RESET;
    end else if (ce) begin
      rx_reg <= rx_next;
      tx_reg <= tx_next;
    end
  end

  assign rxCrc = rx_reg;
  assign txCrc = tx_reg;

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  tx_fold_a: assert property (ce && crcOn && !crcClear && link.takeTx |=>
      tx_reg == crcStep($past(tx_reg), $past(link.txWord), $past(poly), $past(link.wide)))
    else $error("tx CRC fold wrong");
  rx_fold_a: assert property (ce && crcOn && !crcClear && link.rxDone && !skipRx |=>
      rx_reg == crcStep($past(rx_reg), $past(link.rxWord), $past(poly), $past(link.wide)))
    else $error("rx CRC fold wrong");
endmodule // spi_crc_unit
`default_nettype wire

//--- logic/spi_data_crc.sv
// Purpose: SPI data register, CRC registers and AHB-Lite slave
// Assumes: mclk 100 MHz, SPI slave link on pins, zero-wait AHB
// Notes:   Reads are captured in the address phase
`timescale 1ns/1ps
`default_nettype none
`include "spi_crc_cfg.svh"
module spi_data_crc (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  input  wire logic         hsel,
  input  wire logic [7:0]   haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire logic         sck,
  input  wire logic         selN,
  input  wire logic         mosi,
  output logic              miso,
  output logic              misoOe,
  output logic              irq
);
  import spi_crc_pkg::*;

  frame_link_if link ();

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] ctrl_reg, ctrl_next;     // control_one
  word_t       txBuf_reg, txBuf_next;   // Transmit buffer
  logic        txFull_reg, txFull_next; // Transmit buffer holds data
  word_t       rxBuf_reg, rxBuf_next;   // Receive buffer
  logic        rxFull_reg, rxFull_next; // Receive buffer not empty
  word_t       poly_reg, poly_next;     // crc_polynomial
  logic        crc_mismatch_flag_reg, crc_mismatch_flag_next;     // crc_mismatch_flag
  logic        audio_reg, audio_next;   // Audio-serial mode
  logic [2:0]  imask_reg, imask_next;   // Interrupt mask
  logic [2:0]  istat_reg, istat_next;   // Sticky interrupt status
  logic        wrPend_reg, wrPend_next; // Write data phase pending
  logic [7:0]  wrAddr_reg, wrAddr_next; // Write address
  logic [31:0] hrd_reg, hrd_next;       // Read data
  word_t       rxCrc, txCrc;            // Accumulators
  word_t       rxMasked;                // Received frame at width
  logic        take, rdData, crcOn, crcClear, cerrSet, wide, busy;
  logic [31:0] rdMux;

  // Decoded control fields and the bus strobe; audio mode gates the CRC
  // path off at its source, so the accumulators cannot drift while the
  // pins carry audio frames
  assign wide  = ctrl_reg[`BIT_WIDTH];
  assign crcOn = ctrl_reg[`BIT_CRCEN] && !audio_reg;
  assign busy  = link.active || txFull_reg;
  assign take  = hsel && htrans[1] && hready;
  assign rdData = take && !hwrite && haddr == `OFS_DATA;
  assign rxMasked = wide ? link.rxWord : {8'h00, link.rxWord[7:0]};

  // Write strobe for one register in the data phase
  function automatic logic wrHit(logic p, logic [7:0] a, logic [7:0] ofs);
    return p && a == ofs;
  endfunction

  assign crcClear = wrHit(wrPend_reg, wrAddr_reg, `OFS_CTRL) && hwdata[`BIT_CRCEN];
  assign cerrSet  = link.rxDone && ctrl_reg[`BIT_CRCNEXT] && crcOn
                    && rxMasked != rxCrc;

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (haddr)
      `OFS_CTRL:  rdMux[15:0] = ctrl_reg;
      `OFS_STS: begin
        rdMux[`BIT_BUSY] = busy;
        rdMux[`BIT_CRC_MISMATCH_FLAG] = crc_mismatch_flag_reg;
        rdMux[`BIT_TE]   = !txFull_reg;
        rdMux[`BIT_RNE]  = rxFull_reg;
      end
      `OFS_DATA:  rdMux[15:0] = rxBuf_reg;
      `OFS_POLY:  rdMux[15:0] = audio_reg ? 16'h0000 : poly_reg;
      `OFS_RX_CRC_VALUE:  rdMux[15:0] = audio_reg ? 16'h0000 : rxCrc;
      `OFS_TX_CRC_VALUE:  rdMux[15:0] = audio_reg ? 16'h0000 : txCrc;
      `OFS_MODE:  rdMux[`BIT_AUDIO] = audio_reg;
      `OFS_IMASK: rdMux[2:0] = imask_reg;
      `OFS_ISTAT: rdMux[2:0] = istat_reg;
      default:    rdMux = 32'h0000_0000; // Unmapped reads zero
    endcase
  end

  // ----------------------------------------
  // Bus phase tracking
  // ----------------------------------------
  // Address phase is registered so the write lands in the data phase,
  // when hwdata is valid. Reads are captured at the address edge, which
  // keeps hreadyout tied high at the cost of reading one cycle early.
  always_comb begin
    wrPend_next = take && hwrite;
    wrAddr_next = take ? haddr : wrAddr_reg;
    hrd_next    = (take && !hwrite) ? rdMux : hrd_reg;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      hrd_reg    <= 32'h0000_0000;
    end else if (ce) begin
      wrPend_reg <= wrPend_next;
      wrAddr_reg <= wrAddr_next;
      hrd_reg    <= hrd_next;
    end
  end

  // ----------------------------------------
  // Registers and buffers
  // ----------------------------------------
  // Hardware events are applied after software writes in this process, except the
  // data write, which follows the take, so an event landing with a clear is never lost.
  // Limitation: a control write in the cycle a CRC frame lands does not
  // keep the crc-next bit set.
  always_comb begin
    ctrl_next   = ctrl_reg;
    txBuf_next  = txBuf_reg;
    txFull_next = txFull_reg;
    rxBuf_next  = rxBuf_reg;
    rxFull_next = rxFull_reg;
    poly_next   = poly_reg;
    crc_mismatch_flag_next   = crc_mismatch_flag_reg;
    audio_next  = audio_reg;
    imask_next  = imask_reg;
    istat_next  = istat_reg;
    if (wrHit(wrPend_reg, wrAddr_reg, `OFS_CTRL)) begin
      ctrl_next = hwdata[15:0];
    end
    // Engine taking the word frees the buffer; a new write wins
    if (link.takeTx) begin
      txFull_next = 1'b0;
    end
    if (wrHit(wrPend_reg, wrAddr_reg, `OFS_DATA)) begin
      txBuf_next  = wide ? hwdata[15:0] : {8'h00, hwdata[7:0]};
      txFull_next = 1'b1;
    end
    // Reading the data register empties rx; a new frame wins
    if (rdData) begin
      rxFull_next = 1'b0;
    end
    if (link.rxDone) begin
      rxBuf_next  = rxMasked;
      rxFull_next = 1'b1;
      if (ctrl_reg[`BIT_CRCNEXT]) begin
        ctrl_next[`BIT_CRCNEXT] = 1'b0; // CRC frame consumed
      end
    end
    if (wrHit(wrPend_reg, wrAddr_reg, `OFS_POLY)) begin
      poly_next = hwdata[15:0];
    end
    if (wrHit(wrPend_reg, wrAddr_reg, `OFS_STS) && !hwdata[`BIT_CRC_MISMATCH_FLAG]) begin
      crc_mismatch_flag_next = 1'b0;
    end
    if (cerrSet) begin
      crc_mismatch_flag_next = 1'b1;
    end
    if (wrHit(wrPend_reg, wrAddr_reg, `OFS_MODE)) begin
      audio_next = hwdata[`BIT_AUDIO];
    end
    if (wrHit(wrPend_reg, wrAddr_reg, `OFS_IMASK)) begin
      imask_next = hwdata[2:0];
    end
    // Write one clears, events set in the same cycle win
    if (wrHit(wrPend_reg, wrAddr_reg, `OFS_ISTAT)) begin
      istat_next = istat_reg & ~hwdata[2:0];
    end
    istat_next = istat_next | {cerrSet, link.takeTx, link.rxDone};
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg   <= 16'h0000;
      txBuf_reg  <= 16'h0000;
      txFull_reg <= 1'b0;
      rxBuf_reg  <= 16'h0000;
      rxFull_reg <= 1'b0;
      poly_reg   <= `POLY_RESET;
      crc_mismatch_flag_reg   <= 1'b0;
      audio_reg  <= 1'b0;
      imask_reg  <= 3'h0;
      istat_reg  <= 3'h0;
    end else if (ce) begin
      ctrl_reg   <= ctrl_next;
      txBuf_reg  <= txBuf_next;
      txFull_reg <= txFull_next;
      rxBuf_reg  <= rxBuf_next;
      rxFull_reg <= rxFull_next;
      poly_reg   <= poly_next;
      crc_mismatch_flag_reg   <= crc_mismatch_flag_next;
      audio_reg  <= audio_next;
      imask_reg  <= imask_next;
      istat_reg  <= istat_next;
    end
  end

  // ----------------------------------------
  // Link hand-off and submodules
  // ----------------------------------------
  // The engine reads the buffer straight from the flops; a data write
  // racing frame start still wins, as it is applied after the take
  assign link.txWord  = txBuf_reg;
  assign link.txValid = txFull_reg;
  assign link.wide    = wide;
  assign link.run     = ctrl_reg[`BIT_ENABLE];

  // Shift engine: pin synchronisers, frame timing, rx capture
  spi_shift_engine engine (
    .mclk    (mclk),
    .reset_n (reset_n),
    .ce      (ce),
    .sck     (sck),
    .selN    (selN),
    .mosi    (mosi),
    .miso    (miso),
    .misoOe  (misoOe),
    .link    (link.eng)
  );

  // CRC unit: folds each taken tx word and each received frame except the CRC frame
  spi_crc_unit crc (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .ce       (ce),
    .link     (link.mon),
    .poly     (poly_reg),
    .crcOn    (crcOn),
    .crcClear (crcClear),
    .skipRx   (ctrl_reg[`BIT_CRCNEXT]),
    .rxCrc    (rxCrc),
    .txCrc    (txCrc)
  );

  // Zero wait states and no error response: every register answers at
  // once. irq is a level, so a masked event raises it once unmasked.
  assign hrdata    = hrd_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq       = |(istat_reg & imask_reg);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Checks run on mclk and are muted while reset is held; ce low
  // freezes state, so most antecedents require ce
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence dataWrite;
    ce && wrHit(wrPend_reg, wrAddr_reg, `OFS_DATA);
  endsequence
  sequence dataRead;
    ce && rdData;
  endsequence

  tx_load_a: assert property (dataWrite |=> txFull_reg && busy
      && txBuf_reg[7:0] == $past(hwdata[7:0]))
    else $error("data write did not load tx buffer");
  rx_read_a: assert property (dataRead |=> hrdata[15:0] == $past(rxBuf_reg))
    else $error("data read did not return rx buffer");
  rx_upper_a: assert property (!wide && !$past(wide) && $past(ce && link.rxDone)
      |-> rxBuf_reg[15:8] == 8'h00)
    else $error("upper byte not zero in 8-bit mode");
  crc_clear_a: assert property (ce && crcClear |=> rxCrc == 16'h0000 && txCrc == 16'h0000)
    else $error("CRC enable write did not clear");
  audio_idle_a: assert property (ce && audio_reg && !crcClear |=> $stable(rxCrc)
      && $stable(txCrc))
    else $error("CRC moved in audio mode");
  busy_tx_a: assert property (txFull_reg |-> busy ##0 !rdMux[`BIT_TE] || haddr != `OFS_STS)
    else $error("busy low with tx data");
  // The flag holds a further cycle unless software wrote status meanwhile
  crc_mismatch_flag_set_a: assert property (ce && cerrSet |=> crc_mismatch_flag_reg ##1 (crc_mismatch_flag_reg ||
      $past(wrHit(wrPend_reg, wrAddr_reg, `OFS_STS))))
    else $error("CRC mismatch not flagged");
  poly_rst_a: assert property ($rose(reset_n) |-> poly_reg == 16'h0007)
    else $error("polynomial reset value wrong");
endmodule // spi_data_crc
`default_nettype wire

//--- bench/spi_master_model.sv
// Purpose: SPI master model standing on the far side of the slave block
// Assumes: Mode 0, MSB first, link clock period 160 ns
// Notes:   Link clock stands low between frames; gap models a slow master
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  output logic      sck,
  output logic      selN,
  output logic      mosi,
  input  wire logic miso
);
  // Idle: clock low, slave deselected
  initial begin
    sck  = 1'b0;
    selN = 1'b1;
    mosi = 1'b0;
  end

  // ----------------------------------------------------------------
  // One whole frame, data changes while the clock is low
  // ----------------------------------------------------------------
  task automatic xfer(input logic [15:0] tx, input logic wide, input int gap,
                      output logic [15:0] rx);
    int n;
    n  = wide ? 16 : 8;
    rx = 16'h0000;
    selN = 1'b0;
    #(80 + gap);
    for (int i = n - 1; i >= 0; i--) begin
      mosi = tx[i];
      #80 sck = 1'b1;
      rx = {rx[14:0], miso};
      #80 sck = 1'b0;
    end
    #80 selN = 1'b1;
    // Released line shows no stale bit, so a late sample cannot pass by luck
    mosi = ~mosi;
  endtask
endmodule // spi_master_model
`default_nettype wire

//--- bench/test_spi_data_crc.sv
// Purpose: Self-checking bench of the SPI data and CRC register block
// Assumes: AHB-Lite master in the bench, SPI master model on the link
// Notes:   Expected CRCs come from a bench-side bitwise model
`timescale 1ns/1ps
`default_nettype none
`include "spi_crc_cfg.svh"
module test_spi_data_crc;
  import spi_crc_pkg::*;
  logic        mclk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic        sck, selN, mosi, miso, misoOe, irq, wideMode;
  logic [15:0] poly, rxc, txc, got;
  int          errTotal, checks, cyc;
  logic [31:0] ctlRun;

  spi_data_crc i_spi_data_crc (.mclk(mclk), .reset_n(reset_n), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sck(sck), .selN(selN), .mosi(mosi), .miso(miso), .misoOe(misoOe), .irq(irq));
  spi_master_model i_spi_master_model (.sck(sck), .selN(selN), .mosi(mosi), .miso(miso));

  // ----------------------------------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic print_verdict();
    if (errTotal == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // A hung handshake or frame ends the run as a mismatch
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      errTotal++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errTotal++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // AHB-Lite single word transfer, entered just after a rising edge
  // ----------------------------------------------------------------
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // Bitwise MSB-first CRC, init from c, 8-bit mode keeps the low byte
  function automatic logic [15:0] crcf(logic [15:0] c, logic [15:0] d, logic w);
    logic fb;
    for (int i = 15; i >= 0; i--) begin
      if (w || i < 8) begin
        fb = (w ? c[15] : c[7]) ^ d[i];
        c  = {c[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
      end
    end
    return w ? c : {8'h00, c[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // One frame each way, data and both CRCs checked afterwards
  // ----------------------------------------------------------------
  task automatic frame(input logic [15:0] d, input logic [15:0] m);
    logic [15:0] msk;
    msk = wideMode ? 16'hffff : 16'h00ff;
    wr(`OFS_DATA, {16'h0000, d});
    rc(`OFS_STS, 32'h0000_0080);
    i_spi_master_model.xfer(m, wideMode, $urandom_range(0, 300), got);
    chk({16'h0000, got}, {16'h0000, d & msk});
    repeat (10) @(posedge mclk);
    chk({30'h0000_0000, hresp, misoOe}, 32'h0000_0000);
    txc = crcf(txc, d, wideMode);
    rxc = crcf(rxc, m, wideMode);
    rc(`OFS_DATA, {16'h0000, m & msk});
    rc(`OFS_RX_CRC_VALUE, {16'h0000, rxc});
    rc(`OFS_TX_CRC_VALUE, {16'h0000, txc});
    rc(`OFS_STS, 32'h0000_0002);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 8'h00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    errTotal = 0;
    checks = 0;
    cyc = 0;
    void'($urandom(32'h6ba1));
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rc(`OFS_POLY, 32'h0000_0007);
    rc(`OFS_RX_CRC_VALUE, 32'h0000_0000);
    rc(8'h04, 32'h0000_0000);
    poly = 16'($urandom);
    wr(`OFS_POLY, {16'h0000, poly});
    rc(`OFS_POLY, {16'h0000, poly});
    // Width is set while disabled, only then enabled
    for (int w = 0; w < 2; w++) begin
      wideMode = w[0];
      ctlRun = (32'(wideMode) << `BIT_WIDTH) | (32'h1 << `BIT_CRCEN);
      wr(`OFS_CTRL, 32'(wideMode) << `BIT_WIDTH);
      wr(`OFS_CTRL, ctlRun | (32'h1 << `BIT_ENABLE));
      rxc = 16'h0000;
      txc = 16'h0000;
      wr(`OFS_IMASK, 32'h0000_0001);
      frame(16'hffff, 16'h0000);
      repeat (3) frame(16'($urandom), 16'($urandom));
      #1 chk(irq, 1'b1);
      wr(`OFS_ISTAT, 32'h0000_0007);
      #1 chk(irq, 1'b0);
      wr(`OFS_CTRL, ctlRun | (32'h1 << `BIT_ENABLE));
      rc(`OFS_RX_CRC_VALUE, 32'h0000_0000);
      rc(`OFS_TX_CRC_VALUE, 32'h0000_0000);
    end
    // Clear, then send a check frame that cannot match a zero CRC
    wr(`OFS_IMASK, 32'h0000_0004);
    wr(`OFS_CTRL, ctlRun | (32'h1 << `BIT_ENABLE) | (32'h1 << `BIT_CRCNEXT));
    i_spi_master_model.xfer(16'h1234, 1'b1, 0, got);
    repeat (10) @(posedge mclk);
    ahb(1'b0, `OFS_STS, 32'h0000_0000);
    chk(rd & 32'h0000_0010, 32'h0000_0010);
    rc(`OFS_RX_CRC_VALUE, 32'h0000_0000);
    #1 chk(irq, 1'b1);
    wr(`OFS_STS, 32'h0000_0000);
    ahb(1'b0, `OFS_STS, 32'h0000_0000);
    chk(rd & 32'h0000_0010, 32'h0000_0000);
    wr(`OFS_ISTAT, 32'h0000_0007);
    #1 chk(irq, 1'b0);
    // Audio mode reads the polynomial and tx CRC registers as zero
    wr(`OFS_CTRL, 32'h0000_0000);
    wr(`OFS_MODE, 32'h1 << `BIT_AUDIO);
    rc(`OFS_POLY, 32'h0000_0000);
    rc(`OFS_TX_CRC_VALUE, 32'h0000_0000);
    print_verdict();
  end
endmodule // test_spi_data_crc
`default_nettype wire
